//--- include/hlde_regs.vh
`ifndef HLDE_REGS_VH
`define HLDE_REGS_VH

// narrow opcode patterns (16-bit forms)
`define HLDE_T1_IMM_OP 5'h11
`define HLDE_T1_REG_OP 7'h2d
// wide opcode patterns (upper halfword; HLDE_REG_SUB is matched in the lower halfword)
`define HLDE_LIT_HI 8'hf8
`define HLDE_LIT_MID 3'h3
`define HLDE_WIMM_OP 12'hf8b
`define HLDE_BIMM_OP 12'hf83
`define HLDE_REG_SUB 6'h00
// special register numbers
`define HLDE_REG_SP 4'hd
`define HLDE_REG_PC 4'hf
// literal base alignment mask (multiple of 4)
`define HLDE_ALIGN_MASK 32'hfffffffc
// memory error codes from the memory access unit
`define HLDE_MERR_NONE 2'h0
// exception codes reported on exc_code_out
`define HLDE_EXC_NONE 2'h0
`define HLDE_EXC_MEMMGT 2'h1
`define HLDE_EXC_BUS 2'h2
`define HLDE_EXC_USAGE 2'h3

`endif

//--- rtl/hlde_decode.v
`timescale 1ns/100ps
`include "hlde_regs.vh"

module hlde_decode (
  input wire [31:0] instr_in, // 16-bit forms sit in [15:0]
  input wire wide_in, // high for a 32-bit encoding
  output reg ok_out, // a halfword load encoding was recognised
  output reg hint_out, // executes as a no-operation
  output reg undef_out, // undefined combination
  output reg unpred_out, // unpredictable combination
  output reg lit_out, // pc-relative literal form
  output reg reg_form_out, // register-offset form
  output reg index_out, // pre-index
  output reg add_out, // add offset, else subtract
  output reg wback_out, // base writeback
  output reg unpriv_out, // unprivileged access
  output reg [3:0] dest_idx_out, // destination_register_field
  output reg [3:0] base_idx_out, // base_register_field
  output reg [3:0] ofs_idx_out, // offset_register_field
  output reg [1:0] shift_out, // shift_amount_field
  output reg [11:0] imm_out // zero-extended immediate offset
);
  wire [15:0] hw1 = instr_in[31:16];
  wire [15:0] hw2 = instr_in[15:0];
  wire p = hw2[10];
  wire u = hw2[9];
  wire w = hw2[8];

  always @* begin
    ok_out = 1'b0;
    hint_out = 1'b0;
    undef_out = 1'b0;
    unpred_out = 1'b0;
    lit_out = 1'b0;
    reg_form_out = 1'b0;
    index_out = 1'b1;
    add_out = 1'b1;
    wback_out = 1'b0;
    unpriv_out = 1'b0;
    dest_idx_out = hw2[15:12];
    base_idx_out = hw1[3:0];
    ofs_idx_out = hw2[3:0];
    shift_out = 2'h0;
    imm_out = 12'h000;
    if (!wide_in) begin
      dest_idx_out = {1'b0, hw2[2:0]};
      base_idx_out = {1'b0, hw2[5:3]};
      ofs_idx_out = {1'b0, hw2[8:6]};
      if (hw2[15:11] == `HLDE_T1_IMM_OP) begin
        ok_out = 1'b1;
        imm_out = {6'h00, hw2[10:6], 1'b0};
      end else if (hw2[15:9] == `HLDE_T1_REG_OP) begin
        ok_out = 1'b1;
        reg_form_out = 1'b1;
      end
    end else if (hw1[15:8] == `HLDE_LIT_HI && hw1[6:4] == `HLDE_LIT_MID &&
                 hw1[3:0] == `HLDE_REG_PC) begin
      ok_out = 1'b1;
      lit_out = 1'b1;
      add_out = hw1[7];
      imm_out = hw2[11:0];
      hint_out = (dest_idx_out == `HLDE_REG_PC);
      unpred_out = (dest_idx_out == `HLDE_REG_SP);
    end else if (hw1[15:4] == `HLDE_WIMM_OP) begin
      ok_out = 1'b1;
      imm_out = hw2[11:0];
      hint_out = (dest_idx_out == `HLDE_REG_PC);
      unpred_out = (dest_idx_out == `HLDE_REG_SP);
    end else if (hw1[15:4] == `HLDE_BIMM_OP && hw2[11]) begin
      ok_out = 1'b1;
      imm_out = {4'h0, hw2[7:0]};
      if (dest_idx_out == `HLDE_REG_PC && p && !u && !w) begin
        hint_out = 1'b1;
      end else if (p && u && !w) begin
        unpriv_out = 1'b1;
        unpred_out = (dest_idx_out == `HLDE_REG_SP) ||
                     (dest_idx_out == `HLDE_REG_PC);
      end else if (!p && !w) begin
        undef_out = 1'b1;
      end else begin
        index_out = p;
        add_out = u;
        wback_out = w;
        unpred_out = (dest_idx_out == `HLDE_REG_SP) ||
                     (dest_idx_out == `HLDE_REG_PC && w) ||
                     (w && base_idx_out == dest_idx_out);
      end
    end else if (hw1[15:4] == `HLDE_BIMM_OP &&
                 hw2[11:6] == `HLDE_REG_SUB) begin
      ok_out = 1'b1;
      reg_form_out = 1'b1;
      shift_out = hw2[5:4];
      hint_out = (dest_idx_out == `HLDE_REG_PC);
      unpred_out = (dest_idx_out == `HLDE_REG_SP) ||
                   (ofs_idx_out == `HLDE_REG_SP) ||
                   (ofs_idx_out == `HLDE_REG_PC);
    end
  end
endmodule // hlde_decode

//--- rtl/hlde_core.v
`timescale 1ns/100ps
`include "hlde_regs.vh"

module hlde_core (
  input wire core_clk_in, // processor clock
  input wire srst_in, // synchronous reset, active high
  input wire instr_valid_in, // instruction offered this cycle
  input wire [31:0] instr_in, // encoding; 16-bit forms in [15:0]
  input wire instr_wide_in, // instr_in holds a 32-bit encoding
  input wire [31:0] pc_in, // pc value of the instruction
  input wire [31:0] rd_a_data_in, // register file read port a
  input wire [31:0] rd_b_data_in, // register file read port b
  input wire mem_done_in, // memory access unit answer
  input wire [15:0] mem_rdata_in, // loaded halfword
  input wire [1:0] mem_err_in, // 0 none, 1 memory mgmt, 2 bus, 3 usage
  output reg ready_out, // accepting an instruction
  output reg [3:0] rd_a_idx_out, // base register index
  output reg [3:0] rd_b_idx_out, // offset register index
  output reg mem_req_out, // one-cycle access request
  output reg [31:0] mem_addr_out, // access address
  output reg mem_unpriv_out, // check with unprivileged permissions
  output reg wr_en_out, // register file write strobe
  output reg [3:0] wr_idx_out, // register file write index
  output reg [31:0] wr_data_out, // register file write data
  output reg done_out, // one-cycle end of instruction
  output reg [1:0] exc_code_out, // exception raised, valid with done
  output reg unpred_out, // unpredictable encoding, valid with done
  output reg nop_out // executed as no-operation, valid with done
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_WBASE = 3'h3;
  localparam [2:0] ST_WDEST = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  wire d_ok;
  wire d_hint;
  wire d_undef;
  wire d_unpred;
  wire d_lit;
  wire d_reg;
  wire d_index;
  wire d_add;
  wire d_wback;
  wire d_unpriv;
  wire [3:0] d_dest;
  wire [3:0] d_base_idx;
  wire [3:0] d_ofs_idx;
  wire [1:0] d_shift;
  wire [11:0] d_imm;

  hlde_decode u_decode (
    .instr_in(instr_in),
    .wide_in(instr_wide_in),
    .ok_out(d_ok),
    .hint_out(d_hint),
    .undef_out(d_undef),
    .unpred_out(d_unpred),
    .lit_out(d_lit),
    .reg_form_out(d_reg),
    .index_out(d_index),
    .add_out(d_add),
    .wback_out(d_wback),
    .unpriv_out(d_unpriv),
    .dest_idx_out(d_dest),
    .base_idx_out(d_base_idx),
    .ofs_idx_out(d_ofs_idx),
    .shift_out(d_shift),
    .imm_out(d_imm)
  );

  reg [2:0] state;
  reg ok;
  reg hint;
  reg undef;
  reg unpred;
  reg lit;
  reg reg_form;
  reg index;
  reg add;
  reg wback;
  reg unpriv;
  reg [3:0] dest;
  reg [3:0] base_idx;
  reg [1:0] shift;
  reg [11:0] imm;
  reg [31:0] pc;
  reg [31:0] offset_addr;
  reg [15:0] data;

  // address arithmetic on the register values read this cycle
  wire [31:0] base = lit ? (pc & `HLDE_ALIGN_MASK) : rd_a_data_in;
  wire [31:0] offset = reg_form ? (rd_b_data_in << shift) :
                       {20'h00000, imm};
  wire [31:0] next_offset_addr = add ? base + offset : base - offset;
  wire [31:0] next_addr = index ? next_offset_addr : base;

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      ready_out <= 1'b0;
      rd_a_idx_out <= 4'h0;
      rd_b_idx_out <= 4'h0;
      mem_req_out <= 1'b0;
      mem_addr_out <= 32'h00000000;
      mem_unpriv_out <= 1'b0;
      wr_en_out <= 1'b0;
      wr_idx_out <= 4'h0;
      wr_data_out <= 32'h00000000;
      done_out <= 1'b0;
      exc_code_out <= `HLDE_EXC_NONE;
      unpred_out <= 1'b0;
      nop_out <= 1'b0;
      ok <= 1'b0;
      hint <= 1'b0;
      undef <= 1'b0;
      unpred <= 1'b0;
      lit <= 1'b0;
      reg_form <= 1'b0;
      index <= 1'b0;
      add <= 1'b0;
      wback <= 1'b0;
      unpriv <= 1'b0;
      dest <= 4'h0;
      base_idx <= 4'h0;
      shift <= 2'h0;
      imm <= 12'h000;
      pc <= 32'h00000000;
      offset_addr <= 32'h00000000;
      data <= 16'h0000;
    end else begin
      mem_req_out <= 1'b0;
      wr_en_out <= 1'b0;
      done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          ready_out <= 1'b1;
          if (instr_valid_in && ready_out) begin
            ready_out <= 1'b0;
            ok <= d_ok;
            hint <= d_hint;
            undef <= d_undef;
            unpred <= d_unpred;
            lit <= d_lit;
            reg_form <= d_reg;
            index <= d_index;
            add <= d_add;
            wback <= d_wback;
            unpriv <= d_unpriv;
            dest <= d_dest;
            base_idx <= d_base_idx;
            shift <= d_shift;
            imm <= d_imm;
            pc <= pc_in;
            rd_a_idx_out <= d_base_idx;
            rd_b_idx_out <= d_ofs_idx;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          exc_code_out <= `HLDE_EXC_NONE;
          unpred_out <= unpred;
          nop_out <= 1'b0;
          if (!ok || undef) begin
            exc_code_out <= `HLDE_EXC_USAGE;
            state <= ST_DONE;
          end else if (hint || unpred) begin
            nop_out <= 1'b1;
            state <= ST_DONE;
          end else begin
            mem_req_out <= 1'b1;
            mem_addr_out <= next_addr;
            mem_unpriv_out <= unpriv;
            offset_addr <= next_offset_addr;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_done_in) begin
            data <= mem_rdata_in;
            if (mem_err_in != `HLDE_MERR_NONE) begin
              exc_code_out <= mem_err_in;
              state <= ST_DONE;
            end else if (wback) begin
              state <= ST_WBASE;
            end else begin
              state <= ST_WDEST;
            end
          end
        end
        ST_WBASE: begin
          wr_en_out <= 1'b1;
          wr_idx_out <= base_idx;
          wr_data_out <= offset_addr;
          state <= ST_WDEST;
        end
        ST_WDEST: begin
          wr_en_out <= 1'b1;
          wr_idx_out <= dest;
          wr_data_out <= {16'h0000, data};
          state <= ST_DONE;
        end
        ST_DONE: begin
          done_out <= 1'b1;
          ready_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // hlde_core

//--- dv/hlde_core_props.sv
`timescale 1ns/100ps
module hlde_core_props (
  input wire core_clk_in, // clock
  input wire srst_in, // reset
  input wire instr_valid_in, // offer
  input wire mem_done_in, // answer
  input wire [1:0] mem_err_in, // answer code
  input wire ready_out, // idle
  input wire mem_req_out, // access
  input wire wr_en_out, // write
  input wire [3:0] wr_idx_out, // write index
  input wire [31:0] wr_data_out, // write data
  input wire done_out, // end
  input wire [1:0] exc_code_out, // exception
  input wire nop_out // no-op
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_ans;
    mem_done_in && !ready_out;
  endsequence
  sequence s_fin;
    wr_en_out ##[1:2] done_out;
  endsequence
  a_take_path: assert property (instr_valid_in && ready_out |->
    (##2 mem_req_out) or (##3 done_out)) else $error("take path");
  a_load_writes: assert property (s_ans ##0 mem_err_in == 2'h0 |->
    ##[1:3] s_fin) else $error("load end");
  a_fault_end: assert property (s_ans ##0 mem_err_in != 2'h0 |->
    ##2 done_out && exc_code_out == $past(mem_err_in, 2)) else $error("fault");
  a_fault_quiet: assert property (s_ans ##0 mem_err_in != 2'h0 |->
    ##1 !wr_en_out [*2]) else $error("fault write");
  a_hint_quiet: assert property (done_out && nop_out |->
    !$past(mem_req_out) && !$past(mem_req_out, 2) && !$past(wr_en_out))
    else $error("no-op acted");
  a_zero_ext: assert property (wr_en_out ##1 done_out |->
    $past(wr_data_out[31:16]) == 16'h0000) else $error("extension");
  a_base_first: assert property (wr_en_out ##1 wr_en_out |->
    wr_idx_out != $past(wr_idx_out) ##1 done_out) else $error("write order");
  a_ready_done: assert property ($rose(ready_out) &&
    !$past(srst_in, 2) |-> done_out) else $error("ready early");
endmodule // hlde_core_props
bind hlde_core hlde_core_props u_props (.*);

//--- dv/hlde_partner.sv
`timescale 1ns/100ps
module hlde_partner (
  input wire clk_in, // clock
  input wire req_in, // access request
  input wire [31:0] addr_in, // address
  input wire [3:0] ia_in, // index a
  input wire [3:0] ib_in, // index b
  input wire we_in, // write strobe
  input wire [3:0] wi_in, // write index
  input wire [31:0] wd_in, // write data
  input wire [2:0] lat_in, // answer delay
  input wire [1:0] err_in, // answer code
  output wire [31:0] da_out, // data a
  output wire [31:0] db_out, // data b
  output reg done_out, // answer pulse
  output wire [15:0] rd_out, // halfword
  output wire [1:0] er_out // code
);
  reg [31:0] rf [0:15];
  reg [15:0] last = 16'h0000;
  reg [3:0] cnt = 4'h0;
  integer i;
  initial begin
    done_out = 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rf[i] = 32'h40000000 + i * 32'h1004;
  end
  assign da_out = rf[ia_in];
  assign db_out = rf[ib_in];
  // between answers rd_out shows the inverse of the last value and er_out the inverse of err_in
  assign rd_out = done_out ? last : ~last;
  assign er_out = done_out ? err_in : ~err_in;
  always @(posedge clk_in) begin
    done_out <= cnt == 4'h1;
    if (we_in)
      rf[wi_in] <= wd_in;
    if (req_in)
      cnt <= {1'b0, lat_in} + 4'h2;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (cnt == 4'h1)
      last <= addr_in[15:0] ^ 16'ha5c3;
  end
endmodule // hlde_partner

//--- dv/halfword_load_decode_execute_tb.sv
`timescale 1ns/100ps
module halfword_load_decode_execute_tb;
  reg core_clk_in = 1'b0;
  reg srst_in = 1'b1;
  reg instr_valid_in = 1'b0;
  reg [31:0] instr_in = 32'h0;
  reg instr_wide_in = 1'b0;
  reg [31:0] pc_in = 32'h0;
  wire [31:0] rd_a_data_in, rd_b_data_in, mem_addr_out, wr_data_out;
  wire [15:0] mem_rdata_in;
  wire [1:0] mem_err_in, exc_code_out;
  wire [3:0] rd_a_idx_out, rd_b_idx_out, wr_idx_out;
  wire mem_done_in, ready_out, mem_req_out, mem_unpriv_out, wr_en_out;
  wire done_out, unpred_out, nop_out;
  reg [2:0] lat = 3'h0;
  reg [1:0] err = 2'h0;
  reg [31:0] c, pv, o, rf [0:15];
  reg [37:0] q [$];
  reg [3:0] dx, bx, mx;
  reg [11:0] im;
  integer errors = 0, tests_run = 0, cyc = 0, i, j, k;
  hlde_core u_dut (.*);
  hlde_partner u_far (.clk_in(core_clk_in), .req_in(mem_req_out),
    .addr_in(mem_addr_out), .ia_in(rd_a_idx_out), .ib_in(rd_b_idx_out),
    .we_in(wr_en_out), .wi_in(wr_idx_out), .wd_in(wr_data_out),
    .lat_in(lat), .err_in(err), .da_out(rd_a_data_in),
    .db_out(rd_b_data_in), .done_out(mem_done_in), .rd_out(mem_rdata_in),
    .er_out(mem_err_in));
  initial forever #4 core_clk_in = ~core_clk_in;
  task chk(input [37:0] s, input [37:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("ERROR event exp %h seen %h", e, s);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // each result takes the oldest note off the queue
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (!srst_in && (mem_req_out || wr_en_out || done_out))
      chk(mem_req_out ? {5'h08, mem_unpriv_out, mem_addr_out} :
        wr_en_out ? {2'h2, wr_idx_out, wr_data_out} :
        {2'h3, nop_out, unpred_out, exc_code_out, 32'h0},
        q.size() ? q.pop_front() : 38'h0);
    if (cyc == 4000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  task go;
    begin
      k = 0;
      @(posedge core_clk_in);
      #1;
      while (ready_out !== 1'b1 && k < 60) begin
        @(posedge core_clk_in);
        #1 k = k + 1;
      end
      instr_in = c;
      instr_wide_in = c[31:16] != 16'h0;
      pc_in = pv;
      instr_valid_in = 1'b1;
      @(posedge core_clk_in);
      #1 instr_valid_in = 1'b0;
      while (done_out !== 1'b1 && k < 60) begin
        @(posedge core_clk_in);
        #1 k = k + 1;
      end
    end
  endtask
  task nx(input [3:0] f);
    begin
      q.push_back({2'h3, f, 32'h0});
      go;
    end
  endtask
  task ld(input [31:0] ad, input up, input wb);
    begin
      q.push_back({5'h08, up, ad});
      if (err != 2'h0)
        q.push_back({4'hc, err, 32'h0});
      else begin
        if (wb) begin
          q.push_back({2'h2, bx, o});
          rf[bx] = o;
        end
        rf[dx] = {16'h0, ad[15:0] ^ 16'ha5c3};
        q.push_back({2'h2, dx, rf[dx]});
        q.push_back({6'h30, 32'h0});
      end
      go;
    end
  endtask
  initial begin
    k = $urandom(32'h0c79);
    for (i = 0; i < 16; i = i + 1)
      rf[i] = 32'h40000000 + i * 32'h1004;
    repeat (5) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      for (j = 0; j < 8; j = j + 1) begin
        dx = $urandom % 13;
        bx = (dx + 1 + $urandom % 14) % 15;
        mx = $urandom % 13;
        im = j < 2 ? 12'hfff : $urandom % 4096;
        lat = $urandom % 8;
        pv = $urandom;
        o = j[1] ? rf[bx] + im[7:0] : rf[bx] - im[7:0];
        case (i)
          0: begin
            dx[3] = 1'b0;
            bx[3] = 1'b0;
            c = {16'h0, 5'h11, im[4:0], bx[2:0], dx[2:0]};
            ld(rf[bx] + {im[4:0], 1'b0}, 1'b0, 1'b0);
          end
          1: begin
            c = {12'hf8b, bx, j > 5 ? (j == 6 ? 4'hf : 4'hd) : dx, im};
            if (j > 5)
              nx(j == 6 ? 4'h8 : 4'hc);
            else
              ld(rf[bx] + im, 1'b0, 1'b0);
          end
          2: begin
            c = {12'hf83, bx, dx, 1'b1, j[2:0], im[7:0]};
            if (!j[2] && !j[0])
              nx(4'h3);
            else
              ld(j[2] ? o : rf[bx], j[2:0] == 3'h6, j[0]);
          end
          3: begin
            o = pv & 32'hfffffffc;
            if (j == 7) begin
              c = {12'hf83, bx, 8'hfc, im[7:0]};
              nx(4'h8);
            end else if (j == 6) begin
              c = {12'hf83, 4'hf, dx, 6'h0, im[5:0]};
              ld(o - im[5:0], 1'b0, 1'b0);
            end else begin
              c = {8'hf8, j[0], 7'h3f, dx, im};
              ld(j[0] ? o + im : o - im, 1'b0, 1'b0);
            end
          end
          4: begin
            if (j < 2) begin
              dx[3] = 1'b0;
              bx[3] = 1'b0;
              mx[3] = 1'b0;
              c = {16'h0, 7'h2d, mx[2:0], bx[2:0], dx[2:0]};
              ld(rf[bx] + rf[mx], 1'b0, 1'b0);
            end else begin
              if (j > 5)
                mx = j == 6 ? 4'hd : 4'hf;
              c = {12'hf83, bx, dx, 6'h0, j[1:0], mx};
              if (j > 5)
                nx(4'hc);
              else
                ld(rf[bx] + (rf[mx] << j[1:0]), 1'b0, 1'b0);
            end
          end
          default: if (j < 3) begin
            err = j[1:0] + 2'h1;
            c = {12'hf83, bx, dx, 2'h3, j[1], 1'b1, im[7:0]};
            ld(o, 1'b0, 1'b1);
            err = 2'h0;
            c = {12'hf8b, bx, dx, im};
            ld(rf[bx] + im, 1'b0, 1'b0);
          end
        endcase
      end
      $display("test %0d done", i);
    end
    repeat (3) @(posedge core_clk_in);
    chk({6'h0, q.size()}, 38'h0);
    stop_test;
  end
endmodule // halfword_load_decode_execute_tb
